// ---- rtl/digitizer_clock_distribution.v ----
// Clock generator controller with APB registers for the digitizer board
`timescale 1ns/1ps
`default_nettype none
`include "clkdist_consts.vh"
module digitizer_clock_distribution (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ref_clk_in,
  input wire clock_source_switch,
  output reg [3:0] adc_sampling_clock,
  output reg trigger_logic_clock,
  output reg front_clock_out,
  output reg divider_sync_pulse,
  output reg ref_domain_reset_n,
  output reg pll_locked
);

  // ************************************************************
  // Helpers
  // ************************************************************
  // A zero divider would stall the counters, so it acts as one
  function [7:0] div_min1;
    input [7:0] v;
    begin
      div_min1 = (v == 8'h00) ? 8'h01 : v;
    end
  endfunction

  // Three-stage filter: level moves only when stages two and three agree
  function filt_next;
    input cur;
    input s2;
    input s3;
    begin
      filt_next = (s2 == s3) ? s2 : cur;
    end
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  reg ref_s1;
  reg ref_s2;
  reg ref_s3;
  reg ref_lvl;
  reg sw_s1;
  reg sw_s2;
  reg sw_s3;
  reg src_internal;
  reg [7:0] int_cnt;
  reg pll_mode;
  reg out_en;
  reg [7:0] ref_div;
  reg [7:0] fb_div;
  reg [7:0] samp_div;
  reg [7:0] out_div;
  reg [7:0] out_delay;
  reg sw_sync;
  reg [7:0] pd_cnt;
  reg [15:0] vco_cnt;
  reg [2:0] good;
  reg [7:0] loss_cnt;
  reg ref_present;
  reg boot_done;
  reg ref_run_d;
  wire ext_edge;
  wire int_edge;
  wire ref_edge;
  wire [7:0] r_eff;
  wire [7:0] n_eff;
  wire [7:0] s_eff;
  wire [7:0] o_eff;
  wire [15:0] period;
  wire bus_access;
  wire wr_en;
  wire rd_hit;
  wire tick;
  wire [3:0] adc_div_out;
  wire trg_div_out;
  wire out_div_out;
  wire [8:0] trg_div;
  wire [8:0] adc_div;
  wire [8:0] front_div;
  wire next_ref_run;
  wire next_sync;

  assign r_eff = div_min1(ref_div);
  assign n_eff = div_min1(fb_div);
  assign s_eff = div_min1(samp_div);
  assign o_eff = div_min1(out_div);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
      ref_lvl <= 1'b0;
      sw_s1 <= 1'b0;
      sw_s2 <= 1'b0;
      sw_s3 <= 1'b0;
      src_internal <= 1'b0;
    end else begin
      ref_s1 <= ref_clk_in;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      ref_lvl <= filt_next(ref_lvl, ref_s2, ref_s3);
      sw_s1 <= clock_source_switch;
      sw_s2 <= sw_s1;
      sw_s3 <= sw_s2;
      src_internal <= filt_next(src_internal, sw_s2, sw_s3);
    end
  end

  assign ext_edge = ref_s2 & ref_s3 & ~ref_lvl;

  // ************************************************************
  // Reference selection
  // ************************************************************
  // board clock is free running and never switched
  // internal reference is cut from the board clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_cnt <= 8'h00;
    end else if (int_cnt >= `INT_REF_PERIOD - 8'h01) begin
      int_cnt <= 8'h00;
    end else begin
      int_cnt <= int_cnt + 8'h01;
    end
  end

  assign int_edge = (int_cnt == 8'h00);
  assign ref_edge = src_internal ? int_edge : ext_edge;

  // ************************************************************
  // Reference presence watchdog
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loss_cnt <= 8'h00;
      ref_present <= 1'b0;
    end else if (ref_edge) begin
      loss_cnt <= 8'h00;
      ref_present <= 1'b1;
    end else if (loss_cnt < `REF_LOSS_CYCLES) begin
      loss_cnt <= loss_cnt + 8'h01;
    end else begin
      ref_present <= 1'b0;
    end
  end

  // ************************************************************
  // Phase detector and lock
  // ************************************************************
  // Each board clock cycle stands for one oscillator cycle; the
  // oscillator count over one divided reference period must equal
  // the feedback divider for several periods running.
  assign period = vco_cnt + 16'h0001;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_cnt <= 8'h00;
      vco_cnt <= 16'h0000;
      good <= 3'h0;
      pll_locked <= 1'b0;
    end else if (!pll_mode || !ref_present) begin
      pd_cnt <= 8'h00;
      vco_cnt <= 16'h0000;
      good <= 3'h0;
      pll_locked <= 1'b0;
    end else if (ref_edge && (pd_cnt >= r_eff - 8'h01)) begin
      pd_cnt <= 8'h00;
      vco_cnt <= 16'h0000;
      // lock only when dividers fit the reference
      if (period == {8'h00, n_eff}) begin
        if (good < `LOCK_CONFIRM) begin
          good <= good + 3'h1;
        end else begin
          pll_locked <= 1'b1;
        end
      end else begin
        good <= 3'h0;
        pll_locked <= 1'b0;
      end
    end else begin
      if (ref_edge) begin
        pd_cnt <= pd_cnt + 8'h01;
      end
      if (vco_cnt != 16'hFFFF) begin
        vco_cnt <= vco_cnt + 16'h0001;
      end
    end
  end

  // ************************************************************
  // Reference domain reset and divider sync
  // ************************************************************
  // hold reference logic until lock in PLL mode, or until reference present in direct mode
  assign next_ref_run = pll_mode ? pll_locked : ref_present;
  // sync at reset release, on request, and on restart
  assign next_sync = ~boot_done | sw_sync | (next_ref_run & ~ref_run_d);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_done <= 1'b0;
      ref_run_d <= 1'b0;
      ref_domain_reset_n <= 1'b0;
      divider_sync_pulse <= 1'b0;
    end else begin
      boot_done <= 1'b1;
      ref_run_d <= next_ref_run;
      ref_domain_reset_n <= next_ref_run;
      divider_sync_pulse <= next_sync;
    end
  end

  // ************************************************************
  // Derived clock dividers
  // ************************************************************
  // PLL ticks every cycle, direct drive ticks on reference edges
  assign tick = pll_mode ? 1'b1 : ref_edge;
  // sampling clock through the sampling divider
  assign adc_div = {1'b0, s_eff};
  // trigger clock at half the sampling rate
  assign trg_div = pll_mode ? {s_eff, 1'b0} : 9'h002;
  assign front_div = {1'b0, o_eff};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_adc
      clock_divider u_adc (
        .pclk(pclk),
        .presetn(presetn),
        .run(ref_domain_reset_n),
        .tick(tick),
        .sync(divider_sync_pulse),
        .div(adc_div),
        .delay(9'h000),
        .clk_out(adc_div_out[gi])
      );
    end
  endgenerate

  clock_divider u_trg (
    .pclk(pclk),
    .presetn(presetn),
    .run(ref_domain_reset_n),
    .tick(tick),
    .sync(divider_sync_pulse),
    .div(trg_div),
    .delay(9'h000),
    .clk_out(trg_div_out)
  );

  // front divider runs only once enabled
  clock_divider u_front (
    .pclk(pclk),
    .presetn(presetn),
    .run(ref_domain_reset_n & out_en),
    .tick(tick),
    .sync(divider_sync_pulse),
    .div(front_div),
    .delay({1'b0, out_delay}),
    .clk_out(out_div_out)
  );

  // ************************************************************
  // Clock outputs
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_sampling_clock <= 4'h0;
      trigger_logic_clock <= 1'b0;
      front_clock_out <= 1'b0;
    end else begin
      // reference domain clocks stay low while held in reset
      if (!ref_domain_reset_n) begin
        adc_sampling_clock <= 4'h0;
      end else if (pll_mode) begin
        adc_sampling_clock <= adc_div_out;
      end else begin
        // reference drives the converters as it comes
        adc_sampling_clock <= {4{ref_lvl}};
      end
      trigger_logic_clock <= trg_div_out;
      // front output off unless enabled
      // Gated by the registered run level so it drops one board clock cycle after the domain reset
      front_clock_out <= out_en & ref_domain_reset_n & out_div_out;
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  // register bus on the board clock; no wait states
  assign bus_access = psel & penable & pready;
  assign wr_en = bus_access & pwrite & pstrb[0] & ~pslverr;
  assign rd_hit = (paddr == `OFS_CTRL) || (paddr == `OFS_REF_DIV) ||
    (paddr == `OFS_FB_DIV) || (paddr == `OFS_SAMP_DIV) ||
    (paddr == `OFS_OUT_DIV) || (paddr == `OFS_OUT_DELAY) ||
    (paddr == `OFS_STATUS);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= ~rd_hit;
      case (paddr)
        `OFS_CTRL: prdata <= {30'h00000000, out_en, pll_mode};
        `OFS_REF_DIV: prdata <= {24'h000000, ref_div};
        `OFS_FB_DIV: prdata <= {24'h000000, fb_div};
        `OFS_SAMP_DIV: prdata <= {24'h000000, samp_div};
        `OFS_OUT_DIV: prdata <= {24'h000000, out_div};
        `OFS_OUT_DELAY: prdata <= {24'h000000, out_delay};
        `OFS_STATUS: prdata <= {28'h0000000, src_internal, ref_domain_reset_n,
          ref_present, pll_locked};
        default: prdata <= 32'h00000000;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_mode <= `RST_PLL_MODE;
      out_en <= `RST_OUT_EN;
      // default dividers for the internal reference
      ref_div <= `RST_REF_DIV;
      fb_div <= `RST_FB_DIV;
      samp_div <= `RST_SAMP_DIV;
      out_div <= `RST_OUT_DIV;
      out_delay <= `RST_OUT_DELAY;
      sw_sync <= 1'b0;
    end else begin
      sw_sync <= 1'b0;
      if (wr_en) begin
        case (paddr)
          `OFS_CTRL: begin
            pll_mode <= pwdata[`CTRL_PLL_MODE];
            out_en <= pwdata[`CTRL_OUT_EN];
            sw_sync <= pwdata[`CTRL_SYNC];
          end
          `OFS_REF_DIV: ref_div <= pwdata[7:0];
          `OFS_FB_DIV: fb_div <= pwdata[7:0];
          `OFS_SAMP_DIV: samp_div <= pwdata[7:0];
          `OFS_OUT_DIV: out_div <= pwdata[7:0];
          `OFS_OUT_DELAY: out_delay <= pwdata[7:0];
          default: sw_sync <= 1'b0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- rtl/clkdist_consts.vh ----
// Constants for the digitizer clock distribution block
// Behaviour
// - Board oscillator domain runs at a fixed rate, independent of the reference.
// - Board oscillator clock times the register bus and local bus logic.
// - Reference domain times sampling, trigger and acquisition logic.
// - Clock source switch picks external or internal reference; internal is synchronous.
// - Six derived clocks: four sampling, one trigger, one front output.
// - Two modes: direct drive by the reference, or PLL lock to oscillator.
// - Feedback divider resets to 100, reference divider to 5.
// - Sampling clock is the PLL clock through the sampling dividers; direct mode passes the reference straight through.
// - Trigger logic clock runs at half the sampling clock rate.
// - Front output frequency and phase set by output divider and delay.
// - Front output stays off after reset until explicitly enabled.
// - All divider outputs realign on the sync pulse, automatically at reset.
`ifndef CLKDIST_CONSTS_VH
`define CLKDIST_CONSTS_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define OFS_CTRL 12'h000
`define OFS_REF_DIV 12'h004
`define OFS_FB_DIV 12'h008
`define OFS_SAMP_DIV 12'h00C
`define OFS_OUT_DIV 12'h010
`define OFS_OUT_DELAY 12'h014
`define OFS_STATUS 12'h018

// ************************************************************
// Field positions
// ************************************************************
`define CTRL_PLL_MODE 0
`define CTRL_OUT_EN 1
`define CTRL_SYNC 2
`define STAT_LOCKED 0
`define STAT_REF_PRESENT 1
`define STAT_REF_RUN 2
`define STAT_SRC_INTERNAL 3

// ************************************************************
// Reset values
// ************************************************************
`define RST_PLL_MODE 1'b1
`define RST_OUT_EN 1'b0
`define RST_REF_DIV 8'h05
`define RST_FB_DIV 8'h64
`define RST_SAMP_DIV 8'h04
`define RST_OUT_DIV 8'h04
`define RST_OUT_DELAY 8'h00

// ************************************************************
// Timing counts, in board clock cycles; the lock confirm count is in divided reference periods
// ************************************************************
`define INT_REF_PERIOD 8'h14
`define REF_LOSS_CYCLES 8'h40
`define LOCK_CONFIRM 3'h4

`endif

// ---- rtl/clock_divider.v ----
// Programmable clock divider with start delay and realignment
`timescale 1ns/1ps
`default_nettype none
module clock_divider (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire tick,
  input wire sync,
  input wire [8:0] div,
  input wire [8:0] delay,
  output reg clk_out
);
  reg [8:0] cnt;
  reg [8:0] dly;
  wire [8:0] half;
  wire [8:0] cnt_next;

  assign half = (div + 9'h001) >> 1;
  assign cnt_next = (cnt >= div - 9'h001) ? 9'h000 : cnt + 9'h001;

  // ************************************************************
  // Counter and output
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 9'h000;
      dly <= 9'h000;
      clk_out <= 1'b0;
    end else if (!run || sync) begin
      cnt <= 9'h000;
      dly <= delay;
      clk_out <= 1'b0;
    end else if (tick) begin
      if (dly != 9'h000) begin
        dly <= dly - 9'h001;
      end else if (div <= 9'h001) begin
        clk_out <= ~clk_out;
      end else begin
        cnt <= cnt_next;
        clk_out <= (cnt_next < half);
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/ref_clock_source.sv ----
// Far-side reference clock source feeding the reference pin
`timescale 1ns/1ps
`default_nettype none
module ref_clock_source (
  output logic ref_clk,
  input wire logic run,
  input var int half_ns
);
  // ************************************************************
  // Source
  // ************************************************************
  // chosen periods kept
  // Idles low between bursts; the 7 ns offset keeps edges clear of pclk edges
  initial begin
    ref_clk = 1'b0;
    forever begin
      wait (run === 1'b1);
      #7;
      while (run === 1'b1) begin
        #(half_ns) ref_clk = 1'b1;
        #(half_ns) ref_clk = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/clkdist_chk.sv ----
// Port-level checks for the clock distribution block
`timescale 1ns/1ps
`default_nettype none
module clkdist_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ref_clk_in,
  input wire logic clock_source_switch,
  input wire logic [3:0] adc_sampling_clock,
  input wire logic trigger_logic_clock,
  input wire logic front_clock_out,
  input wire logic divider_sync_pulse,
  input wire logic ref_domain_reset_n,
  input wire logic pll_locked
);
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_after_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("pready missing after setup");
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  a_ready_in_access: assert property (p_ready_in_access)
    else $error("pready outside access");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("pslverr without pready");
  property p_idle_zero;
    !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("read data or error outside access");
  property p_adc_same;
    adc_sampling_clock == {4{adc_sampling_clock[0]}};
  endproperty
  a_adc_same: assert property (p_adc_same)
    else $error("sampling clocks differ");
  property p_sync_one;
    divider_sync_pulse |=> !divider_sync_pulse;
  endproperty
  a_sync_one: assert property (p_sync_one)
    else $error("sync pulse longer than one cycle");
  property p_sync_boot;
    $rose(presetn) |=> divider_sync_pulse;
  endproperty
  a_sync_boot: assert property (p_sync_boot)
    else $error("no sync pulse after reset");
  property p_lock_run;
    $rose(pll_locked) |=> $rose(ref_domain_reset_n) && divider_sync_pulse;
  endproperty
  a_lock_run: assert property (p_lock_run)
    else $error("reference domain not released after lock");
  property p_front_off;
    !ref_domain_reset_n ##1 !ref_domain_reset_n |-> !front_clock_out;
  endproperty
  a_front_off: assert property (p_front_off)
    else $error("front clock drives while reference domain held");
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the clock distribution block
`timescale 1ns/1ps
`default_nettype none
`include "clkdist_consts.vh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, sw, run, pready, pslverr, ref_clk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, adc;
  logic trg, front, sync, rdrn, locked, bad;
  int half_ns, miscompares, samples_checked, dl;
  digitizer_clock_distribution i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk),
    .clock_source_switch(sw), .adc_sampling_clock(adc), .trigger_logic_clock(trg),
    .front_clock_out(front), .divider_sync_pulse(sync), .ref_domain_reset_n(rdrn),
    .pll_locked(locked));
  ref_clock_source i_src (.ref_clk(ref_clk), .run(run), .half_ns(half_ns));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb_answer", 32'h1, {31'h0, n < 20});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, s, rd, er);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e,
    input logic ee);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, 4'hF, rd, er);
    chk(nm, e, rd);
    chk(nm, {31'h0, ee}, {31'h0, er});
  endtask
  function automatic logic sig(int k);
    case (k)
      0: return adc[0];
      1: return trg;
      2: return front;
      3: return locked;
      default: return rdrn;
    endcase
  endfunction
  task automatic wlev(input string nm, input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(nm, {31'h0, v}, {31'h0, sig(k)});
  endtask
  task automatic per(input string nm, input int k, input logic [31:0] e);
    int n, r, t0;
    logic p, c;
    n = 0;
    r = 0;
    t0 = 0;
    p = 1'b1;
    while (r < 2 && n < 600) begin
      @(posedge pclk);
      #1;
      n++;
      c = sig(k);
      if (c === 1'b1 && p === 1'b0) begin
        r++;
        if (r == 1) t0 = n;
      end
      p = c;
    end
    chk(nm, e, n - t0);
  endtask
  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #500000;
    miscompares++;
    end_sim();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, run, bad} = '0;
    sw = 1'b1;
    half_ns = 250;
    repeat (8) @(posedge pclk);
    chk("reset_outputs", 32'h0, {adc, trg, front, sync, rdrn, locked, pready});
    presetn <= 1'b1;
    rdc("ctrl", `OFS_CTRL, 32'h1, 1'b0);
    rdc("ref_div", `OFS_REF_DIV, 32'h5, 1'b0);
    rdc("fb_div", `OFS_FB_DIV, 32'h64, 1'b0);
    rdc("samp_div", `OFS_SAMP_DIV, 32'h4, 1'b0);
    rdc("out_div", `OFS_OUT_DIV, 32'h4, 1'b0);
    rdc("out_delay", `OFS_OUT_DELAY, 32'h0, 1'b0);
    rdc("unmapped", 12'h01C, 32'h0, 1'b1);
    wlev("lock_int", 3, 1'b1, 2000);
    wlev("run_int", 4, 1'b1, 4);
    rdc("status_int", `OFS_STATUS, 32'hF, 1'b0);
    repeat (200) begin
      @(posedge pclk);
      #1;
      if (front !== 1'b0) bad = 1'b1;
    end
    chk("front_off", 32'h0, {31'h0, bad});
    per("adc_div4", 0, 32'h4);
    per("trg_div4", 1, 32'h8);
    wr(`OFS_OUT_DELAY, 32'h3, 4'h1);
    rdc("out_delay_wr", `OFS_OUT_DELAY, 32'h3, 1'b0);
    wr(`OFS_CTRL, 32'h3, 4'h1);
    dl = 0;
    while (front !== 1'b1 && dl < 20) begin
      @(posedge pclk);
      #1;
      dl++;
    end
    chk("front_delay", 32'h5, dl);
    wr(`OFS_SAMP_DIV, 32'h6, 4'h1);
    wr(`OFS_OUT_DIV, 32'h5, 4'h1);
    wr(`OFS_OUT_DIV, 32'h9, 4'h0);
    wr(`OFS_STATUS, 32'h0, 4'h1);
    rdc("strobe_off", `OFS_OUT_DIV, 32'h5, 1'b0);
    rdc("status_ro", `OFS_STATUS, 32'hF, 1'b0);
    wr(`OFS_CTRL, 32'h7, 4'h1);
    bad = 1'b0;
    repeat (3) begin
      #1;
      if (sync === 1'b1) bad = 1'b1;
      @(posedge pclk);
    end
    chk("soft_sync", 32'h1, {31'h0, bad});
    rdc("ctrl_sync_clear", `OFS_CTRL, 32'h3, 1'b0);
    per("adc_div6", 0, 32'h6);
    per("trg_div6", 1, 32'hC);
    per("front_div5", 2, 32'h5);
    @(posedge pclk);
    sw <= 1'b0;
    wlev("loss_unlock", 3, 1'b0, 200);
    wlev("loss_hold", 4, 1'b0, 4);
    @(posedge pclk);
    run <= 1'b1;
    wlev("lock_ext", 3, 1'b1, 2000);
    rdc("status_ext", `OFS_STATUS, 32'h7, 1'b0);
    run <= 1'b0;
    wr(`OFS_CTRL, 32'h2, 4'h1);
    half_ns = 100;
    run <= 1'b1;
    wlev("direct_run", 4, 1'b1, 300);
    wlev("direct_nolock", 3, 1'b0, 4);
    per("adc_direct", 0, 32'h8);
    per("trg_direct", 1, 32'h10);
    per("front_direct", 2, 32'h28);
    end_sim();
  end
endmodule
bind digitizer_clock_distribution clkdist_chk i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ref_clk_in(ref_clk_in), .clock_source_switch(clock_source_switch),
  .adc_sampling_clock(adc_sampling_clock), .trigger_logic_clock(trigger_logic_clock),
  .front_clock_out(front_clock_out), .divider_sync_pulse(divider_sync_pulse),
  .ref_domain_reset_n(ref_domain_reset_n), .pll_locked(pll_locked));
`default_nettype wire
